// ==== inc/backup_pkg.sv ====
// constants and field layouts for the backup register bank with tamper detect
package backup_pkg;
  // bus widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned MAX_WORDS = 42;

  // register byte offsets
  localparam logic [7:0] DATA_LO_FIRST = 8'h04;
  localparam logic [7:0] DATA_LO_LAST = 8'h28;
  localparam logic [7:0] DATA_HI_FIRST = 8'h40;
  localparam logic [7:0] DATA_HI_LAST = 8'hbc;
  localparam logic [7:0] CAL_OFFSET = 8'h2c;
  localparam logic [7:0] CR_OFFSET = 8'h30;
  localparam logic [7:0] CSR_OFFSET = 8'h34;
  // word address minus this gives the data word index
  localparam logic [5:0] LO_INDEX_BASE = 6'h01;
  localparam logic [5:0] HI_INDEX_BASE = 6'h06;

  // field positions
  localparam int unsigned CAL_LSB = 0;
  localparam int unsigned CAL_W = 7;
  localparam int unsigned CCO_BIT = 7;
  localparam int unsigned PULSE_OUT_ENABLE_BIT = 8;
  localparam int unsigned PULSE_OUT_SELECT_BIT = 9;
  localparam int unsigned TPE_BIT = 0;
  localparam int unsigned TAMPER_ACTIVE_LEVEL_BIT = 1;
  localparam int unsigned CTE_BIT = 0;
  localparam int unsigned CTI_BIT = 1;
  localparam int unsigned TAMPER_IRQ_ENABLE_BIT = 2;
  localparam int unsigned TEF_BIT = 8;
  localparam int unsigned TIF_BIT = 9;

  // counts
  localparam int unsigned CAL_WINDOW_LOG2 = 20;
  localparam int unsigned CCO_DIV_LOG2 = 6;

  // values after reset
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [6:0] CAL_RESET = 7'h00;

  // calibration register fields
  typedef struct packed {
    logic       pulse_out_select;
    logic       pulse_out_enable;
    logic       cco;
    logic [6:0] cal;
  } calib_type;

  // tamper control fields
  typedef struct packed {
    logic tamper_active_level;
    logic tamper_pin_enable;
  } tamper_ctrl_type;
endpackage

// ==== hdl/backup_regs_tamper_detect.sv ====
// backup data words, tamper detection and rtc calibration output on apb
//
// Behaviour
// - active level bit 0 detects rising edge, 1 falling; only while enabled
// - every tamper event clears all backup data words to zero
// - detector sees pin level and enable; enabling at active level gives event
// - event with irq enable set raises irq flag and irq request
// - clear-irq write or dropping irq enable clears flag and request
// - event sets event flag; clear-event write clears it and rearms detector
// - while event flag set, data words held cleared and writes dropped
// - tamper irq is never a low-power wakeup source
// - irq enable and flag cleared only by system reset or standby wakeup
// - data words are 16 bits, cleared only by backup reset or tamper
// - data words at 0x04..0x28 and 0x40..0xBC, up to 42 words
// - calibration clock bit drives rtc clock divided by 64 onto pin
// - calibration clock bit cleared when main supply powers off
// - pulse enable drives alarm (select 0) or second (select 1) pulse
// - pulse enable and select cleared only by backup domain reset
// - seven-bit field drops that many rtc ticks per 2^20-tick window
// - tamper enable 0 frees the pin for gpio, 1 gives tamper function
// - clear bits read zero; reserved bits read zero
// - detection keeps working and clearing data while main supply off
// - data, calibration and control writes blocked until unlock is set
`timescale 1ns/1ps

module backup_regs_tamper_detect #(
  parameter int unsigned NUM_WORDS = 42
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        backup_reset_n,
  input  wire logic        standby_wakeup,
  input  wire logic        vdd_off,
  input  wire logic        backup_write_unlock,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tamper_pin_in,
  output logic             tamper_pin_out,
  output logic             tamper_pin_oe,
  output logic             tamper_gpio_mode,
  input  wire logic        rtc_tick,
  input  wire logic        rtc_alarm_pulse,
  input  wire logic        rtc_second_pulse,
  output logic             rtc_tick_calibrated,
  output logic             tamper_irq
);

  // refuse word counts beyond the two address runs
  if (NUM_WORDS < 1 || NUM_WORDS > backup_pkg::MAX_WORDS) begin : g_bad_words
    $error("NUM_WORDS must lie between 1 and 42");
  end

  // state
  logic [15:0]                 data_q [NUM_WORDS];
  backup_pkg::calib_type       calib_q;
  backup_pkg::tamper_ctrl_type ctrl_q;
  logic                        tamper_irq_enable_q;
  logic                        tif_q;
  logic                        tef_q;
  logic                        pin_s1_q;
  logic                        pin_s2_q;
  logic                        pin_s3_q;
  logic                        pin_state_q;
  logic                        level_q;
  logic [5:0]                  div_q;
  logic [19:0]                 window_q;
  logic                        pready_q;
  logic                        pslverr_q;
  logic [31:0]                 prdata_q;
  logic                        pin_out_q;
  logic                        pin_oe_q;
  logic                        gpio_mode_q;
  logic                        tick_out_q;

  // address decode
  wire logic       in_lo;
  wire logic       in_hi;
  wire logic [5:0] word_idx;
  wire logic       hit_data;
  wire logic       hit_cal;
  wire logic       hit_cr;
  wire logic       hit_csr;
  wire logic       hit_any;

  assign in_lo = paddr >= backup_pkg::DATA_LO_FIRST &&
                 paddr <= backup_pkg::DATA_LO_LAST && paddr[1:0] == 2'h0;
  assign in_hi = paddr >= backup_pkg::DATA_HI_FIRST &&
                 paddr <= backup_pkg::DATA_HI_LAST && paddr[1:0] == 2'h0;
  // two runs folded onto one index space, low run first
  assign word_idx = in_lo ? paddr[7:2] - backup_pkg::LO_INDEX_BASE
                          : paddr[7:2] - backup_pkg::HI_INDEX_BASE;
  assign hit_data = (in_lo || in_hi) && (32'(word_idx) < NUM_WORDS);
  assign hit_cal = paddr == backup_pkg::CAL_OFFSET;
  assign hit_cr = paddr == backup_pkg::CR_OFFSET;
  assign hit_csr = paddr == backup_pkg::CSR_OFFSET;
  assign hit_any = hit_data || hit_cal || hit_cr || hit_csr;

  // write strobes, taken only at the access edge
  wire logic wr_ok;
  wire logic wr_data;
  wire logic wr_cal;
  wire logic wr_cr;
  wire logic wr_csr;

  assign wr_ok = psel && penable && pready_q && pwrite;
  assign wr_data = wr_ok && hit_data && backup_write_unlock;
  assign wr_cal = wr_ok && hit_cal && backup_write_unlock;
  assign wr_cr = wr_ok && hit_cr && backup_write_unlock;
  assign wr_csr = wr_ok && hit_csr;

  // csr side effects, only the defined bits are looked at
  wire logic clear_irq;
  wire logic clear_event;
  wire logic tamper_irq_enable_next;

  assign clear_irq = wr_csr && pwdata[backup_pkg::CTI_BIT];
  assign clear_event = wr_csr && pwdata[backup_pkg::CTE_BIT];
  assign tamper_irq_enable_next = wr_csr ? pwdata[backup_pkg::TAMPER_IRQ_ENABLE_BIT] : tamper_irq_enable_q;

  // tamper detector: level of pin at its active state, gated by enable
  wire logic active_level;
  wire logic tamper_event;

  assign active_level = (ctrl_q.tamper_active_level ? ~pin_state_q : pin_state_q)
                        && ctrl_q.tamper_pin_enable;
  // disarmed while the event flag stands; clear-event rearms it
  assign tamper_event = active_level && !level_q && !tef_q;

  // pin synchroniser, a change counts once the last two stages agree
  always_ff @(posedge clock) begin
    if (!backup_reset_n) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= tamper_pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // filtered pin level and detector history; backup domain, so it runs
  // with main supply off
  always_ff @(posedge clock) begin
    if (!backup_reset_n) begin
      pin_state_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      if (pin_s2_q == pin_s3_q) begin
        pin_state_q <= pin_s3_q;
      end
      level_q <= active_level;
    end
  end

  // data words; cleared on the event itself and held while flag stands
  always_ff @(posedge clock) begin
    if (!backup_reset_n || tamper_event || tef_q) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        data_q[i] <= backup_pkg::WORD_RESET;
      end
    end else if (wr_data) begin
      data_q[word_idx] <= pwdata[15:0];
    end
  end

  // calibration register; pulse bits only see backup reset
  always_ff @(posedge clock) begin
    if (!backup_reset_n) begin
      calib_q <= '{pulse_out_select: 1'b0, pulse_out_enable: 1'b0, cco: 1'b0,
                   cal: backup_pkg::CAL_RESET};
    end else if (vdd_off) begin
      calib_q.cco <= 1'b0;
    end else if (wr_cal) begin
      calib_q.pulse_out_select <= pwdata[backup_pkg::PULSE_OUT_SELECT_BIT];
      calib_q.pulse_out_enable <= pwdata[backup_pkg::PULSE_OUT_ENABLE_BIT];
      calib_q.cco <= pwdata[backup_pkg::CCO_BIT];
      calib_q.cal <= pwdata[backup_pkg::CAL_LSB +: backup_pkg::CAL_W];
    end
  end

  // tamper control lives in the backup domain
  always_ff @(posedge clock) begin
    if (!backup_reset_n) begin
      ctrl_q <= '0;
    end else if (wr_cr) begin
      ctrl_q.tamper_active_level <= pwdata[backup_pkg::TAMPER_ACTIVE_LEVEL_BIT];
      ctrl_q.tamper_pin_enable <= pwdata[backup_pkg::TPE_BIT];
    end
  end

  // event flag: a new event wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!backup_reset_n) begin
      tef_q <= 1'b0;
    end else if (tamper_event) begin
      tef_q <= 1'b1;
    end else if (clear_event) begin
      tef_q <= 1'b0;
    end
  end

  // irq enable and flag: system reset and standby wakeup only
  always_ff @(posedge clock) begin
    if (!reset_n || standby_wakeup) begin
      tamper_irq_enable_q <= 1'b0;
      tif_q <= 1'b0;
    end else begin
      tamper_irq_enable_q <= tamper_irq_enable_next;
      if (tamper_event && tamper_irq_enable_q) begin
        tif_q <= 1'b1;
      end else if (clear_irq || !tamper_irq_enable_next) begin
        tif_q <= 1'b0;
      end
    end
  end

  // rtc tick divider for the calibration clock; free running so the
  // pin toggles as soon as the bit is set
  always_ff @(posedge clock) begin
    if (!backup_reset_n) begin
      div_q <= '0;
    end else if (rtc_tick) begin
      div_q <= div_q + 6'h01;
    end
  end

  // calibration window: the first cal ticks of each window are dropped
  always_ff @(posedge clock) begin
    if (!backup_reset_n) begin
      window_q <= '0;
      tick_out_q <= 1'b0;
    end else begin
      tick_out_q <= rtc_tick && (window_q >= 20'(calib_q.cal));
      if (rtc_tick) begin
        window_q <= window_q + 20'h0_0001;
      end
    end
  end

  // pin output select; tamper enable takes the pin back
  wire logic pin_out_d;
  wire logic pin_oe_d;
  wire logic pulse_sel;

  assign pulse_sel = calib_q.pulse_out_select ? rtc_second_pulse : rtc_alarm_pulse;
  assign pin_out_d = ctrl_q.tamper_pin_enable ? 1'b0 :
                     calib_q.cco ? div_q[backup_pkg::CCO_DIV_LOG2-1] :
                     calib_q.pulse_out_enable ? pulse_sel : 1'b0;
  assign pin_oe_d = !ctrl_q.tamper_pin_enable && (calib_q.cco || calib_q.pulse_out_enable);

  // pin drivers registered so the pads never see decode glitches
  always_ff @(posedge clock) begin
    if (!backup_reset_n) begin
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
      gpio_mode_q <= 1'b1;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
      gpio_mode_q <= !ctrl_q.tamper_pin_enable;
    end
  end

  // read data; clear bits and reserved bits come back as zero
  logic [31:0] rd_word;

  always_comb begin
    rd_word = '0;
    if (hit_data) begin
      rd_word[15:0] = data_q[word_idx];
    end else if (hit_cal) begin
      rd_word[backup_pkg::PULSE_OUT_SELECT_BIT] = calib_q.pulse_out_select;
      rd_word[backup_pkg::PULSE_OUT_ENABLE_BIT] = calib_q.pulse_out_enable;
      rd_word[backup_pkg::CCO_BIT] = calib_q.cco;
      rd_word[backup_pkg::CAL_LSB +: backup_pkg::CAL_W] = calib_q.cal;
    end else if (hit_cr) begin
      rd_word[backup_pkg::TAMPER_ACTIVE_LEVEL_BIT] = ctrl_q.tamper_active_level;
      rd_word[backup_pkg::TPE_BIT] = ctrl_q.tamper_pin_enable;
    end else if (hit_csr) begin
      rd_word[backup_pkg::TIF_BIT] = tif_q;
      rd_word[backup_pkg::TEF_BIT] = tef_q;
      rd_word[backup_pkg::TAMPER_IRQ_ENABLE_BIT] = tamper_irq_enable_q;
    end
  end

  // apb slave: answer ready in the first access cycle, no wait states;
  // read data captured in setup so it can come from a flop
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= psel && !penable;
      if (psel && !penable) begin
        pslverr_q <= !hit_any;
        prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // irq request straight from the flag; no wakeup path exists
  assign tamper_irq = tif_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tamper_pin_out = pin_out_q;
  assign tamper_pin_oe = pin_oe_q;
  assign tamper_gpio_mode = gpio_mode_q;
  assign rtc_tick_calibrated = tick_out_q;

endmodule

// ==== testbench/backup_checker_assertions.sv ====
// assertions on the backup bank ports
`timescale 1ns/1ps
module backup_checker (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        standby_wakeup,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rtc_tick,
  input wire logic        rtc_tick_calibrated,
  input wire logic        tamper_irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // decoded bus phases
  wire setup  = psel && !penable;
  wire rd_ack = pready && !pwrite;
  wire csr_wr = psel && penable && pready && pwrite && paddr == 8'h34;
  property p_answer; setup |=> pready ##1 !pready; endproperty
  a_answer: assert property (p_answer) else $error("bad answer timing");
  property p_unmapped; setup && paddr == 8'h38 |=> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole not refused");
  property p_data_hi; rd_ack && paddr == 8'h04 |-> prdata[31:16] == 16'h0000; endproperty
  a_data_hi: assert property (p_data_hi) else $error("data upper bits set");
  property p_ctrl_rsv; rd_ack && paddr == 8'h30 |-> prdata[31:2] == 30'h0; endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("control reserved set");
  property p_csr_rsv;
    rd_ack && paddr == 8'h34 |-> prdata[1:0] == 2'b00 && prdata[7:3] == 5'h00;
  endproperty
  a_csr_rsv: assert property (p_csr_rsv) else $error("status low bits set");
  property p_cti; csr_wr && pwdata[1] |=> !tamper_irq; endproperty
  a_cti: assert property (p_cti) else $error("irq survived clear");
  property p_tpie0; csr_wr && !pwdata[2] |=> !tamper_irq; endproperty
  a_tpie0: assert property (p_tpie0) else $error("irq survived disable");
  property p_standby; standby_wakeup |=> !tamper_irq; endproperty
  a_standby: assert property (p_standby) else $error("irq survived wakeup");
  property p_tick; rtc_tick_calibrated |-> $past(rtc_tick); endproperty
  a_tick: assert property (p_tick) else $error("tick without source");
  c_irq: cover property ($rose(tamper_irq));
  c_err: cover property (pready && pslverr);
  c_drop: cover property (rtc_tick ##1 !rtc_tick_calibrated);
endmodule
bind backup_regs_tamper_detect backup_checker CHK (.clock(clock), .reset_n(reset_n),
  .standby_wakeup(standby_wakeup), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rtc_tick(rtc_tick), .rtc_tick_calibrated(rtc_tick_calibrated), .tamper_irq(tamper_irq));

// ==== testbench/tamper_switch.sv ====
// tamper switch on the pin, settling after a lag
`timescale 1ns/1ps
module tamper_switch (
  input  wire logic       clock,
  input  wire logic       closed,
  input  wire logic [3:0] lag,
  output logic            level
);
  logic [3:0] wait_q = 4'h0;
  logic       goal_q = 1'b0;
  initial level = 1'b0;
  // push-pull contact, never floats; lag makes it prompt or slow
  always @(posedge clock) begin
    if (closed != goal_q) begin
      goal_q <= closed;
      wait_q <= lag;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else begin
      level <= goal_q;
    end
  end
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the backup bank with tamper detect
`timescale 1ns/1ps
module testbench;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        backup_reset_n = 1'b0;
  logic        standby_wakeup = 1'b0;
  logic        vdd_off = 1'b0;
  logic        unlock = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, pin_out, pin_oe, gpio, sw_level, tick_cal, tamper_irq, err;
  logic        rtc_tick = 1'b0;
  logic        alarm = 1'b0;
  logic        second = 1'b0;
  logic        closed = 1'b0;
  logic        tick_en = 1'b0;
  logic        sel = 1'b0;
  logic        want = 1'b0;
  logic [31:0] seed = 32'h7498_4396;
  logic [31:0] kept [6];
  logic [7:0]  addr [6] = '{8'h04, 8'h28, 8'h40, 8'hbc, 8'h08, 8'h7c};
  int          num_errors = 0;
  int          comparisons = 0;
  int          ticks = 0;
  int          cal_ticks = 0;
  int          t0, c0;
  always #25 clock = ~clock;
  // pin level: design drive wins over the switch
  wire pin_in = pin_oe ? pin_out : sw_level;
  backup_regs_tamper_detect #(.NUM_WORDS(42)) DUT (
    .clock(clock), .reset_n(reset_n), .backup_reset_n(backup_reset_n),
    .standby_wakeup(standby_wakeup), .vdd_off(vdd_off), .backup_write_unlock(unlock),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tamper_pin_in(pin_in),
    .tamper_pin_out(pin_out), .tamper_pin_oe(pin_oe), .tamper_gpio_mode(gpio),
    .rtc_tick(rtc_tick), .rtc_alarm_pulse(alarm), .rtc_second_pulse(second),
    .rtc_tick_calibrated(tick_cal), .tamper_irq(tamper_irq));
  tamper_switch SW (.clock(clock), .closed(closed), .lag(seed[3:0]), .level(sw_level));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [31:0] dmask(input logic [31:0] v);
    return {16'h0000, v[15:0]};
  endfunction
  function automatic logic [31:0] csr(input logic tamper_irq_flag, input logic tamper_event_flag, input logic ie);
    return {22'h0, tamper_irq_flag, tamper_event_flag, 5'h00, ie, 2'b00};
  endfunction
  // rtc side; ticks gated so a calibration window starts clean
  always @(posedge clock) begin
    seed <= xs(seed);
    rtc_tick <= tick_en & ~rtc_tick & seed[0];
    alarm <= seed[5];
    second <= seed[9];
    want <= sel ? second : alarm;
    ticks <= ticks + int'(rtc_tick);
    cal_ticks <= cal_ticks + int'(tick_cal);
  end
  task automatic close_out;
    $display("counts: %0d compared, %0d mismatched", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    num_errors++;
    $display("FAIL %0t %s", $time, m);
    close_out();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fail("no pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic wait_irq;
    int n;
    for (n = 0; n < 100 && tamper_irq !== 1'b1; n++) @(posedge clock);
    if (tamper_irq !== 1'b1) fail("no tamper irq");
  endtask
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    backup_reset_n <= 1'b1;
    apb(1'b1, 8'h04, 32'h0000_1234);
    rdc(8'h04, 32'h0000_0000);
    unlock <= 1'b1;
    foreach (addr[i]) begin
      kept[i] = seed;
      apb(1'b1, addr[i], kept[i]);
      rdc(addr[i], dmask(kept[i]));
    end
    apb(1'b0, 8'h38, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    $display("test map done");
    // all ones: only the ten implemented bits stick
    apb(1'b1, 8'h2c, 32'hffff_ffff);
    rdc(8'h2c, 32'h0000_03ff);
    chk({31'h0, pin_oe}, 32'h0000_0001);
    vdd_off <= 1'b1;
    @(posedge clock);
    vdd_off <= 1'b0;
    rdc(8'h2c, 32'h0000_037f);
    for (int s = 1; s >= 0; s--) begin
      apb(1'b1, 8'h2c, {22'h0, s[0], 9'h100});
      sel <= s[0];
      repeat (2) @(posedge clock);
      repeat (6) begin
        @(negedge clock);
        chk({31'h0, pin_out}, {31'h0, want});
      end
    end
    // system reset mid-run, driven on the rising edge like all stimulus
    @(posedge clock);
    reset_n <= 1'b0;
    @(posedge clock);
    reset_n <= 1'b1;
    rdc(8'h2c, 32'h0000_0100);
    rdc(8'hbc, dmask(kept[3]));
    apb(1'b1, 8'h2c, 32'h0000_0000);
    $display("test pin output done");
    // switch rests at the inactive level, then trips
    for (int p = 0; p < 2; p++) begin
      closed <= p[0];
      repeat (20) @(posedge clock);
      apb(1'b1, 8'h34, 32'h0000_0004);
      apb(1'b1, 8'h30, {30'h0, p[0], 1'b1});
      apb(1'b1, 8'h04, kept[0]);
      chk({31'h0, gpio}, 32'h0000_0000);
      closed <= ~p[0];
      wait_irq();
      rdc(8'h04, 32'h0000_0000);
      rdc(8'h34, csr(1'b1, 1'b1, 1'b1));
      apb(1'b1, 8'h28, kept[1]);
      rdc(8'h28, 32'h0000_0000);
      apb(1'b1, 8'h34, 32'h0000_0007);
      repeat (10) @(posedge clock);
      rdc(8'h34, csr(1'b0, 1'b0, 1'b1));
      apb(1'b1, 8'h30, {30'h0, p[0], 1'b0});
      apb(1'b1, 8'h30, {30'h0, p[0], 1'b1});
      wait_irq();
      standby_wakeup <= 1'b1;
      @(posedge clock);
      standby_wakeup <= 1'b0;
      rdc(8'h34, csr(1'b0, 1'b1, 1'b0));
      apb(1'b1, 8'h30, {30'h0, p[0], 1'b0});
      apb(1'b1, 8'h34, 32'h0000_0001);
      rdc(8'h34, 32'h0000_0000);
    end
    $display("test tamper done");
    backup_reset_n <= 1'b0;
    @(posedge clock);
    backup_reset_n <= 1'b1;
    rdc(8'hbc, 32'h0000_0000);
    // calibration clock out too, tamper stays off after backup reset
    apb(1'b1, 8'h2c, 32'h0000_0085);
    t0 = ticks;
    c0 = cal_ticks;
    tick_en <= 1'b1;
    repeat (400) @(posedge clock);
    tick_en <= 1'b0;
    repeat (4) @(posedge clock);
    chk(32'(cal_ticks - c0), 32'(ticks - t0 - 5));
    chk({31'h0, pin_out}, 32'((ticks - t0) / 32 % 2));
    $display("test calibration done");
    close_out();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clock);
    fail("watchdog");
  end
endmodule
